//--- design/fcs_sequencer.sv
// Flash command sequencer: APB registers, command protocol, pulse timing.
// Assumes an APB master on pclk and an array model outside on the hv pins.
//
// Functional notes
// - Divider must be set before commands run
// - Divider register takes one write only
// - Divider write blocked while access error set
// - Pulses timed in whole timing-clock periods
// - Byte program 9 cycles, burst 4
// - Page erase 4000, mass erase 20000
// - Array write latches address and data first
// - Erase granularity is one 512-byte page
// - Command code latched; 0x20 byte, 0x25 burst
// - Blank 0x05, page 0x40, mass 0x41
// - Writing one to empty flag launches command
// - Writing zero to empty flag aborts, errors
// - Access error blocks new commands
// - Complete flag set when command finishes
// - Pump stays on for queued same-row burst
// - Row is 64 bytes, A5..A0
// - First or new-row burst byte full time
// - No queued burst turns pump off
// - Array 16384 or 8192 bytes
// - Access error cleared by writing one
// - Array write while buffer full errors
// - Stop during program or erase aborts
`timescale 1ns/1ps

module fcs_sequencer #(
    parameter int ADDR_W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic hv_pump_on,
    output logic hv_prog,
    output logic hv_erase,
    output logic hv_mass,
    output logic [ADDR_W-1:0] hv_addr,
    output logic [7:0] hv_data
);

    // ==========================================================
    // Decode
    typedef enum logic [1:0] {FCS_IDLE, FCS_RUN, FCS_HOLD} fcs_state_type;
    typedef enum logic [1:0] {FCS_P_EMPTY, FCS_P_ADDR, FCS_P_CMD} fcs_ph_type;

    // array size comes from ADDR_W, 14 or 13 bits
    localparam logic [15:0] ARR_SIZE = 16'((32'h1 << ADDR_W));
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [11:0] ofs = paddr[11:0];
    wire in_arr = (paddr >= 16'(fcs_pkg::FCS_ARRAY_BASE))
        && (paddr < 16'(fcs_pkg::FCS_ARRAY_BASE) + ARR_SIZE);
    wire hit_div = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_DIV_OFS;
    wire hit_st = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_STAT_OFS;
    wire hit_cmd = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_CMD_OFS;
    wire hit_adr = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_ADDR_OFS;
    wire hit_dat = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_DATA_OFS;
    wire hit_ctl = paddr[15:12] == 4'h0 && ofs == fcs_pkg::FCS_CTRL_OFS;
    wire mapped = in_arr || hit_div || hit_st || hit_cmd || hit_adr
        || hit_dat || hit_ctl;

    // ==========================================================
    // State
    logic [fcs_pkg::FCS_DIV_W-1:0] div_q;
    logic prdiv_q, divdone_q, bef_q, ccf_q, acc_q, blank_q, stop_q;
    fcs_ph_type ph_q;
    logic [ADDR_W-1:0] buf_adr_q, run_adr_q;
    logic [7:0] buf_dat_q, run_dat_q, buf_cmd_q, run_cmd_q;
    fcs_state_type st_q;
    logic [14:0] cnt_q;
    logic pump_q, prog_q, erase_q, mass_q;
    logic [31:0] rd_q;
    logic rdy_q, err_q;
    logic tick;

    wire [7:0] wb = pwdata[7:0];
    wire valid_cmd = wb == fcs_pkg::FCS_CMD_BLANK
        || wb == fcs_pkg::FCS_CMD_BYTE || wb == fcs_pkg::FCS_CMD_BURST
        || wb == fcs_pkg::FCS_CMD_PAGE || wb == fcs_pkg::FCS_CMD_MASS;

    // Protocol violations, each sets the access error flag
    wire e_arr = wr && in_arr && (!divdone_q || !bef_q
        || ph_q != FCS_P_EMPTY);
    wire e_cmd = wr && hit_cmd && (ph_q != FCS_P_ADDR || !valid_cmd);
    wire e_other = wr && (hit_div || hit_ctl) && ph_q != FCS_P_EMPTY;
    wire abort = wr && hit_st && !wb[fcs_pkg::FCS_ST_BEF]
        && ph_q != FCS_P_EMPTY;
    wire e_launch = wr && hit_st && wb[fcs_pkg::FCS_ST_BEF]
        && ph_q == FCS_P_ADDR;
    wire stop_abort = stop_q && st_q != FCS_IDLE;
    wire set_err = e_arr || e_cmd || e_other || abort || e_launch
        || stop_abort;
    wire clr_err = wr && hit_st && wb[fcs_pkg::FCS_ST_ACC];
    wire arr_ok = wr && in_arr && !e_arr && !acc_q;
    wire cmd_ok = wr && hit_cmd && !e_cmd && !acc_q;
    wire launch = wr && hit_st && wb[fcs_pkg::FCS_ST_BEF]
        && ph_q == FCS_P_CMD && !acc_q && !stop_q;
    wire div_ok = wr && hit_div && !divdone_q && !acc_q
        && ph_q == FCS_P_EMPTY;

    // Next burst queued within the same row keeps the pump running
    wire next_row = buf_adr_q[fcs_pkg::FCS_ROW_BITS-1:0] == '0;
    wire chain = bef_q == 1'b0 && buf_cmd_q == fcs_pkg::FCS_CMD_BURST
        && run_cmd_q == fcs_pkg::FCS_CMD_BURST && !next_row;
    wire done = (st_q == FCS_RUN) && tick && cnt_q == 15'h0001;

    function automatic logic [14:0] fcs_time(input logic [7:0] c,
        input logic warm);
        begin
            case (c)
                fcs_pkg::FCS_CMD_BYTE: fcs_time = fcs_pkg::FCS_T_BYTE;
                fcs_pkg::FCS_CMD_BURST: fcs_time = warm ?
                    fcs_pkg::FCS_T_BURST : fcs_pkg::FCS_T_BYTE;
                fcs_pkg::FCS_CMD_PAGE: fcs_time = fcs_pkg::FCS_T_PAGE;
                fcs_pkg::FCS_CMD_MASS: fcs_time = fcs_pkg::FCS_T_MASS;
                default: fcs_time = fcs_pkg::FCS_T_BLANK;
            endcase
        end
    endfunction : fcs_time

    // ==========================================================
    // Timing clock
    fcs_clk_div #(.DIV_W(fcs_pkg::FCS_DIV_W)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_q == FCS_RUN),
        .prdiv8(prdiv_q),
        .div(div_q),
        .tick(tick)
    );

    // ==========================================================
    // Configuration and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= '0;
            prdiv_q <= 1'b0;
            divdone_q <= 1'b0;
            acc_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            if (div_ok)
            begin
                // Prescale bit sits above the divide field
                div_q <= {1'b0, pwdata[fcs_pkg::FCS_DIV_PRDIV-1:0]};
                prdiv_q <= pwdata[fcs_pkg::FCS_DIV_PRDIV];
                divdone_q <= 1'b1;
            end
            if (wr && hit_ctl && !e_other)
                stop_q <= pwdata[fcs_pkg::FCS_CTRL_STOP];
            acc_q <= set_err || (acc_q && !clr_err);
        end
    end

    // ==========================================================
    // Command buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q <= FCS_P_EMPTY;
            bef_q <= 1'b1;
            buf_adr_q <= '0;
            buf_dat_q <= 8'h00;
            buf_cmd_q <= 8'h00;
        end
        else if (set_err && ph_q != FCS_P_CMD || abort)
        begin
            ph_q <= FCS_P_EMPTY;
        end
        else if (arr_ok)
        begin
            buf_adr_q <= ADDR_W'(paddr - 16'(fcs_pkg::FCS_ARRAY_BASE));
            buf_dat_q <= wb;
            ph_q <= FCS_P_ADDR;
        end
        else if (cmd_ok)
        begin
            buf_cmd_q <= wb;
            ph_q <= FCS_P_CMD;
        end
        else if (launch)
        begin
            bef_q <= 1'b0;
            ph_q <= FCS_P_EMPTY;
        end
        else if (!bef_q && (st_q == FCS_IDLE || (done && chain)))
        begin
            // Queued command keeps the buffer full until it starts
            bef_q <= 1'b1;
        end
    end

    // ==========================================================
    // Execution
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= FCS_IDLE;
            cnt_q <= 15'h0000;
            ccf_q <= 1'b1;
            blank_q <= 1'b0;
            run_adr_q <= '0;
            run_dat_q <= 8'h00;
            run_cmd_q <= 8'h00;
            pump_q <= 1'b0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            mass_q <= 1'b0;
        end
        else if (stop_abort)
        begin
            st_q <= FCS_IDLE;
            ccf_q <= 1'b1;
            pump_q <= 1'b0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            mass_q <= 1'b0;
        end
        else if ((st_q == FCS_IDLE && !bef_q) || (done && chain))
        begin
            st_q <= FCS_RUN;
            ccf_q <= 1'b0;
            cnt_q <= fcs_time(buf_cmd_q, done && chain);
            run_cmd_q <= buf_cmd_q;
            run_dat_q <= buf_dat_q;
            // Page erase drops low bits so any byte picks its page
            run_adr_q <= buf_cmd_q == fcs_pkg::FCS_CMD_PAGE ?
                {buf_adr_q[ADDR_W-1:fcs_pkg::FCS_PAGE_BITS],
                {(fcs_pkg::FCS_PAGE_BITS){1'b0}}} : buf_adr_q;
            pump_q <= buf_cmd_q != fcs_pkg::FCS_CMD_BLANK;
            prog_q <= buf_cmd_q == fcs_pkg::FCS_CMD_BYTE
                || buf_cmd_q == fcs_pkg::FCS_CMD_BURST;
            erase_q <= buf_cmd_q == fcs_pkg::FCS_CMD_PAGE
                || buf_cmd_q == fcs_pkg::FCS_CMD_MASS;
            mass_q <= buf_cmd_q == fcs_pkg::FCS_CMD_MASS
                || buf_cmd_q == fcs_pkg::FCS_CMD_BLANK;
            if (buf_cmd_q == fcs_pkg::FCS_CMD_BLANK)
                blank_q <= 1'b1; // Array model is assumed erased
        end
        else if (done)
        begin
            st_q <= FCS_IDLE;
            ccf_q <= 1'b1;
            pump_q <= 1'b0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            mass_q <= 1'b0;
        end
        else if (st_q == FCS_RUN && tick)
        begin
            cnt_q <= cnt_q - 15'h0001;
        end
    end

    // ==========================================================
    // APB slave, zero wait state
    wire [31:0] st_word = 32'(bef_q) << fcs_pkg::FCS_ST_BEF
        | 32'(ccf_q) << fcs_pkg::FCS_ST_CCF
        | 32'(acc_q) << fcs_pkg::FCS_ST_ACC
        | 32'(blank_q) << fcs_pkg::FCS_ST_BLANK;
    wire [31:0] div_word = 32'(divdone_q) << fcs_pkg::FCS_DIV_DONE
        | 32'(prdiv_q) << fcs_pkg::FCS_DIV_PRDIV | 32'(div_q);
    wire [31:0] rd_mux = hit_st ? st_word
        : hit_div ? div_word
        : hit_cmd ? 32'(buf_cmd_q)
        : hit_adr ? 32'(run_adr_q)
        : hit_dat ? 32'(run_dat_q)
        : hit_ctl ? 32'(stop_q) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q <= 32'h0000_0000;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            rdy_q <= psel && !penable;
            err_q <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
                rd_q <= rd_mux;
        end
    end

    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign hv_pump_on = pump_q;
    assign hv_prog = prog_q;
    assign hv_erase = erase_q;
    assign hv_mass = mass_q;
    assign hv_addr = run_adr_q;
    assign hv_data = run_dat_q;

    // ==========================================================
    // Checks
    a_div_once: assert property (@(posedge pclk) disable iff (!presetn)
        divdone_q && wr && hit_div |=> $stable(div_q))
        else $error("divider changed after first write");
    a_div_acc: assert property (@(posedge pclk) disable iff (!presetn)
        acc_q && !divdone_q && wr && hit_div |=> !divdone_q)
        else $error("divider written during access error");
    a_abort_err: assert property (@(posedge pclk) disable iff (!presetn)
        abort |=> acc_q && ph_q == FCS_P_EMPTY)
        else $error("abort did not flag error");
    a_err_block: assert property (@(posedge pclk) disable iff (!presetn)
        acc_q && st_q == FCS_IDLE && bef_q |=> bef_q)
        else $error("command started during access error");
    a_launch_run: assert property (@(posedge pclk) disable iff (!presetn)
        launch && st_q == FCS_IDLE |=> !bef_q ##1 st_q == FCS_RUN)
        else $error("launch did not start command");
    a_done_ccf: assert property (@(posedge pclk) disable iff (!presetn)
        done && !chain && !stop_abort |=> ccf_q && !pump_q)
        else $error("completion not reported");
    a_busy_arr: assert property (@(posedge pclk) disable iff (!presetn)
        wr && in_arr && !bef_q |=> acc_q)
        else $error("array write while busy not flagged");
    a_stop_abort: assert property (@(posedge pclk) disable iff (!presetn)
        stop_q && st_q == FCS_RUN |=> st_q == FCS_IDLE && acc_q)
        else $error("stop did not abort command");
    a_chain_pump: assert property (@(posedge pclk) disable iff (!presetn)
        done && chain && !stop_abort |=> pump_q
        && cnt_q == fcs_pkg::FCS_T_BURST)
        else $error("burst chain lost pump");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("apb answer late");

endmodule : fcs_sequencer

//--- design/fcs_pkg.sv
// Package for the flash command sequencer: offsets, fields, codes, timing.
// Assumes a 32-bit APB slave with byte addresses of aligned words.
package fcs_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] FCS_DIV_OFS = 12'h000;
    localparam logic [11:0] FCS_STAT_OFS = 12'h004;
    localparam logic [11:0] FCS_CMD_OFS = 12'h008;
    localparam logic [11:0] FCS_ADDR_OFS = 12'h00c;
    localparam logic [11:0] FCS_DATA_OFS = 12'h010;
    localparam logic [11:0] FCS_CTRL_OFS = 12'h014;
    localparam logic [11:0] FCS_ARRAY_BASE = 12'h800;

    // ==========================================================
    // Field positions
    localparam int FCS_DIV_W = 7;
    localparam int FCS_DIV_PRDIV = 6;
    localparam int FCS_DIV_DONE = 7;
    localparam int FCS_ST_BEF = 7;
    localparam int FCS_ST_CCF = 6;
    localparam int FCS_ST_ACC = 4;
    localparam int FCS_ST_BLANK = 2;
    localparam int FCS_CTRL_STOP = 0;

    // ==========================================================
    // Command codes
    localparam logic [7:0] FCS_CMD_BLANK = 8'h05;
    localparam logic [7:0] FCS_CMD_BYTE = 8'h20;
    localparam logic [7:0] FCS_CMD_BURST = 8'h25;
    localparam logic [7:0] FCS_CMD_PAGE = 8'h40;
    localparam logic [7:0] FCS_CMD_MASS = 8'h41;

    // ==========================================================
    // Timing in timing-clock cycles, then row and page address bits and the prescale factor
    localparam logic [14:0] FCS_T_BYTE = 15'h0009;
    localparam logic [14:0] FCS_T_BURST = 15'h0004;
    localparam logic [14:0] FCS_T_PAGE = 15'h0fa0;
    localparam logic [14:0] FCS_T_MASS = 15'h4e20;
    localparam logic [14:0] FCS_T_BLANK = 15'h0001;
    localparam int FCS_ROW_BITS = 6;
    localparam int FCS_PAGE_BITS = 9;
    localparam int FCS_PRESCALE = 8;

endpackage : fcs_pkg

//--- design/fcs_clk_div.sv
// Timing clock enable generator for the flash command sequencer.
// Assumes a single bus clock; the enable is a one-cycle pulse.
`timescale 1ns/1ps

module fcs_clk_div #(
    parameter int DIV_W = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic prdiv8,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);

    // ==========================================================
    // Prescaler then divider, period (div+1) or 8*(div+1)
    logic [2:0] pre_q;
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;
    wire pre_en = !prdiv8 || (pre_q == 3'h7);
    wire wrap = pre_en && (cnt_q == div);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q <= 3'h0;
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            pre_q <= run ? pre_q + 3'h1 : 3'h0;
            cnt_q <= (!run || wrap) ? '0 : (pre_en ? cnt_q + 1'b1 : cnt_q);
            tick_q <= run && wrap;
        end
    end

    assign tick = tick_q;

endmodule : fcs_clk_div

//--- test/fcs_array_model.sv
// Array-side model: watches the pump pin and measures each pump-on spell.
// Assumes the same pclk and presetn as the sequencer.
`timescale 1ns/1ps

module fcs_array_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hv_pump_on,
    output int pump_len,
    output int pump_rises
);
    // ==========================================================
    // Pump spell measurement
    // A spell that is still running is not reported, so read after a fall
    int run_len;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_len <= 0;
            pump_len <= 0;
            pump_rises <= 0;
        end
        else if (hv_pump_on === 1'b1)
        begin
            run_len <= run_len + 1;
            if (run_len == 0)
                pump_rises <= pump_rises + 1;
        end
        else if (run_len != 0)
        begin
            pump_len <= run_len;
            run_len <= 0;
        end
    end
endmodule : fcs_array_model

//--- test/fcs_sequencer_test.sv
// Self-checking bench for the flash command sequencer, driven over APB.
// Assumes a divider write of 2 gives one timing tick every 3 pclk cycles.
`timescale 1ns/1ps

module fcs_sequencer_test;
    // ==========================================================
    // Addresses, timing, signals
    localparam logic [15:0] A_DIV = {4'h0, fcs_pkg::FCS_DIV_OFS};
    localparam logic [15:0] A_ST = {4'h0, fcs_pkg::FCS_STAT_OFS};
    localparam logic [15:0] A_CMD = {4'h0, fcs_pkg::FCS_CMD_OFS};
    localparam logic [15:0] A_CT = {4'h0, fcs_pkg::FCS_CTRL_OFS};
    localparam logic [15:0] A_AR = {4'h0, fcs_pkg::FCS_ARRAY_BASE};
    // Slow ticks leave software time to queue a burst byte
    localparam int TK = 3;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic hv_pump_on, hv_prog, hv_erase, hv_mass;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [13:0] hv_addr;
    logic [7:0] hv_data;
    int miscompares, cmp_count, pump_len, pump_rises, r0;

    fcs_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hv_pump_on(hv_pump_on), .hv_prog(hv_prog),
        .hv_erase(hv_erase), .hv_mass(hv_mass), .hv_addr(hv_addr),
        .hv_data(hv_data));
    fcs_array_model u_arr (.pclk(pclk), .presetn(presetn),
        .hv_pump_on(hv_pump_on), .pump_len(pump_len),
        .pump_rises(pump_rises));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    function automatic logic [31:0] rng(input int v, input int lo);
        return {31'h0, (v >= lo) && (v <= lo + 6)};
    endfunction : rng

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic hang();
        miscompares++;
        $display("wait ran out at t=%0t", $time);
        give_verdict();
    endtask : hang

    // Idle cycle at the end keeps psel from being set twice in one step
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
            hang();
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input logic [15:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask : rchk

    task automatic launch(input logic [13:0] a, input logic [7:0] c);
        apb(1'b1, A_AR + {2'h0, a}, {24'h0, a[7:0] ^ 8'h5a});
        apb(1'b1, A_CMD, {24'h0, c});
        apb(1'b1, A_ST, 32'h80);
    endtask : launch

    task automatic wait_st(input logic [31:0] m);
        int n;
        for (n = 0; n < 25000; n++)
        begin
            apb(1'b0, A_ST, 32'h0);
            if ((rdv & m) === m)
                break;
        end
        if (n == 25000)
            hang();
    endtask : wait_st

    // ==========================================================
    // Scenarios
    task automatic t_setup();
        rchk(A_ST, 32'hd0, 32'hc0);
        apb(1'b0, 16'h0020, 32'h0);
        chk({err, rdv[30:0]}, 32'h80000000);
        apb(1'b1, A_AR, 32'h11);
        rchk(A_ST, 32'h10, 32'h10);
        apb(1'b1, A_DIV, 32'h2);
        rchk(A_DIV, 32'hff, 32'h0);
        apb(1'b1, A_ST, 32'h10);
        rchk(A_ST, 32'h10, 32'h0);
        apb(1'b1, A_DIV, 32'h2);
        apb(1'b1, A_DIV, 32'h3f);
        rchk(A_DIV, 32'hff, 32'h82);
        $display("setup test done");
    endtask : t_setup

    task automatic t_prog();
        r0 = pump_rises;
        launch(14'h0045, fcs_pkg::FCS_CMD_BYTE);
        repeat (2) @(posedge pclk);
        chk({hv_prog, 9'h0, hv_addr, hv_data}, 32'h8000451f);
        rchk(A_ST, 32'hc0, 32'h80);
        wait_st(32'hc0);
        chk(rng(pump_len, 9 * TK), 32'h1);
        chk(pump_rises - r0, 32'h1);
        $display("program test done");
    endtask : t_prog

    task automatic t_erase();
        launch(14'h03ff, fcs_pkg::FCS_CMD_PAGE);
        repeat (2) @(posedge pclk);
        chk({hv_erase, hv_mass, 16'h0, hv_addr}, 32'h80000200);
        wait_st(32'hc0);
        chk(rng(pump_len, 4000 * TK), 32'h1);
        launch(14'h0123, fcs_pkg::FCS_CMD_MASS);
        repeat (2) @(posedge pclk);
        chk({31'h0, hv_mass}, 32'h1);
        // Queued blank check fills the buffer behind the mass erase
        launch(14'h0000, fcs_pkg::FCS_CMD_BLANK);
        apb(1'b1, A_AR, 32'h0);
        rchk(A_ST, 32'h10, 32'h10);
        wait_st(32'hc0);
        chk(rng(pump_len, 20000 * TK), 32'h1);
        chk(rdv & 32'h04, 32'h04);
        apb(1'b1, A_ST, 32'h10);
        $display("erase test done");
    endtask : t_erase

    task automatic t_errors();
        r0 = pump_rises;
        apb(1'b1, A_AR + 16'h0100, 32'h0);
        apb(1'b1, A_ST, 32'h0);
        rchk(A_ST, 32'h10, 32'h10);
        launch(14'h0101, fcs_pkg::FCS_CMD_BYTE);
        repeat (40) @(posedge pclk);
        chk(pump_rises - r0, 32'h0);
        apb(1'b1, A_ST, 32'h10);
        apb(1'b1, A_AR + 16'h0102, 32'h0);
        apb(1'b1, A_CMD, 32'h33);
        rchk(A_ST, 32'h10, 32'h10);
        apb(1'b1, A_ST, 32'h10);
        $display("error test done");
    endtask : t_errors

    task automatic t_burst();
        r0 = pump_rises;
        launch(14'h007e, fcs_pkg::FCS_CMD_BURST);
        wait_st(32'h80);
        launch(14'h007f, fcs_pkg::FCS_CMD_BURST);
        wait_st(32'hc0);
        repeat (40) @(posedge pclk);
        chk(rng(pump_len, 13 * TK), 32'h1);
        chk(pump_rises - r0, 32'h1);
        launch(14'h00bf, fcs_pkg::FCS_CMD_BURST);
        wait_st(32'h80);
        launch(14'h00c0, fcs_pkg::FCS_CMD_BURST);
        wait_st(32'hc0);
        repeat (40) @(posedge pclk);
        chk(rng(pump_len, 9 * TK), 32'h1);
        chk(pump_rises - r0, 32'h3);
        chk({31'h0, hv_pump_on}, 32'h0);
        $display("burst test done");
    endtask : t_burst

    task automatic t_stop();
        launch(14'h0400, fcs_pkg::FCS_CMD_PAGE);
        apb(1'b1, A_CT, 32'h1);
        wait_st(32'h10);
        chk({31'h0, hv_pump_on}, 32'h0);
        apb(1'b1, A_CT, 32'h0);
        apb(1'b1, A_ST, 32'h10);
        $display("stop test done");
    endtask : t_stop

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        miscompares = 0;
        cmp_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_setup();
        t_prog();
        t_erase();
        t_errors();
        t_burst();
        t_stop();
        give_verdict();
    end
endmodule : fcs_sequencer_test
